/* src/bfec_event_counter.sv */
/*
 * One bus fabric performance counter with its event selector and register port.
 * Assumes arbiter strobes are synchronous one-cycle pulses, one per event,
 * and the register port presents one request per cycle with sel high.
 */
`timescale 1ns/1ps
module bfec_event_counter #(
	parameter int CNT_W = bfec_pkg::CNT_W,
	parameter int SEL_W = bfec_pkg::SEL_W
) (
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire bfec_pkg::bfec_evt_s         evt,
	input  wire bfec_pkg::bfec_req_s         req,
	output logic [bfec_pkg::DATA_W-1:0]      rdata_ff,
	output logic                             rvalid_ff
);

	localparam int DW = bfec_pkg::DATA_W;
	localparam int PW = $clog2(bfec_pkg::PORT_N);

	logic [SEL_W-1:0] choice_ff;
	logic [CNT_W-1:0] count_ff;

	// register decode
	wire logic hit_count;
	wire logic hit_choice;
	wire logic wr_count;
	wire logic wr_choice;
	wire logic rd_any;

	assign hit_count  = req.sel && (req.addr == bfec_pkg::OFS_COUNT);
	assign hit_choice = req.sel && (req.addr == bfec_pkg::OFS_CHOICE);
	assign wr_count   = hit_count && req.wr;
	assign wr_choice  = hit_choice && req.wr;
	assign rd_any     = req.sel && !req.wr;

	// event selection
	wire logic          code_valid;
	wire logic [PW-1:0] port_idx;
	wire logic          want_all;
	wire logic          evt_hit;

	// codes past the last pair point at no port and never count
	assign code_valid = (choice_ff <= bfec_pkg::CODE_LAST);
	assign port_idx   = PW'(choice_ff >> 1);
	assign want_all   = choice_ff[0];
	// even code picks the contested strobe, odd code every access
	assign evt_hit    = code_valid &&
	                    (want_all ? evt.access[port_idx] : evt.contested[port_idx]);

	// select register
	wire logic [SEL_W-1:0] nxt_choice;

	// reserved bits 31:5 are dropped on write
	assign nxt_choice = wr_choice ? req.wdata[SEL_W-1:0] : choice_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			choice_ff <= bfec_pkg::SEL_RST;
		end else begin
			choice_ff <= nxt_choice;
		end
	end

	// counter; write data value is irrelevant, any write clears it to zero, or to one when a selected event arrives in the same cycle
	bfec_sat_counter #(
		.W (CNT_W)
	) u_counter (
		.clk      (clk),
		.nrst     (nrst),
		.clear    (wr_count),
		.inc      (evt_hit),
		.count_ff (count_ff)
	);

	// read path; unmapped addresses read as zero, reserved bits as zero
	wire logic [DW-1:0] rd_count;
	wire logic [DW-1:0] rd_choice;
	wire logic [DW-1:0] nxt_rdata;

	assign rd_count  = {{(DW-CNT_W){1'b0}}, count_ff};
	assign rd_choice = {{(DW-SEL_W){1'b0}}, choice_ff};
	assign nxt_rdata = !rd_any    ? rdata_ff  :
	                   hit_count  ? rd_count  :
	                   hit_choice ? rd_choice : '0;

	// read data held until the next read; valid is a one-cycle pulse
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff  <= '0;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff  <= nxt_rdata;
			rvalid_ff <= rd_any;
		end
	end

	// checks
	localparam logic [CNT_W-1:0] CNT_MAX = '1;
	localparam logic [SEL_W-1:0] SEL_HI  = bfec_pkg::CODE_LAST;

	a_count_sat_hold: assert property (@(posedge clk) disable iff (!nrst)
		(count_ff == CNT_MAX && !wr_count) |=> (count_ff == CNT_MAX))
		else $error("counter left its maximum without a clear");

	a_count_step_one: assert property (@(posedge clk) disable iff (!nrst)
		(evt_hit && !wr_count && count_ff != CNT_MAX) |=>
		(count_ff == $past(count_ff) + 24'h000001))
		else $error("counter did not step by one on a selected event");

	a_count_idle_hold: assert property (@(posedge clk) disable iff (!nrst)
		(!evt_hit && !wr_count) |=> $stable(count_ff))
		else $error("counter changed without event or clear");

	a_write_clears: assert property (@(posedge clk) disable iff (!nrst)
		wr_count |=> (count_ff == (($past(evt_hit)) ? 24'h000001 : bfec_pkg::CNT_RST)))
		else $error("count write did not clear the counter");

	// one idle cycle between clear and read is the usual software pattern
	a_clear_reads_zero: assert property (@(posedge clk) disable iff (!nrst)
		(wr_count && !evt_hit) ##1 (!req.sel && !evt_hit) ##1
		(rd_any && hit_count && !evt_hit) |=>
		(rdata_ff == '0) && rvalid_ff)
		else $error("read after clear did not return zero");

	a_choice_write: assert property (@(posedge clk) disable iff (!nrst)
		wr_choice |=> (choice_ff == $past(req.wdata[SEL_W-1:0])))
		else $error("select field did not take written value");

	a_choice_hold: assert property (@(posedge clk) disable iff (!nrst)
		!wr_choice |=> $stable(choice_ff))
		else $error("select field changed without a write");

	// register port answer timing
	a_read_valid_pulse: assert property (@(posedge clk) disable iff (!nrst)
		rd_any |=> rvalid_ff)
		else $error("read was not answered the next cycle");

	a_no_spurious_valid: assert property (@(posedge clk) disable iff (!nrst)
		!rd_any |=> !rvalid_ff)
		else $error("read valid raised without a read");

	a_rdata_hold: assert property (@(posedge clk) disable iff (!nrst)
		!rd_any |=> $stable(rdata_ff))
		else $error("read data changed without a read");

	a_count_readback: assert property (@(posedge clk) disable iff (!nrst)
		(rd_any && hit_count) |=> (rdata_ff[DW-1:CNT_W] == '0) &&
		(rdata_ff[CNT_W-1:0] == $past(count_ff)))
		else $error("count readback wrong or upper bits set");

	a_unmapped_zero: assert property (@(posedge clk) disable iff (!nrst)
		(rd_any && !hit_count && !hit_choice) |=> (rdata_ff == '0))
		else $error("unmapped read returned nonzero data");

	a_choice_readback: assert property (@(posedge clk) disable iff (!nrst)
		(rd_any && hit_choice) |=> (rdata_ff[DW-1:SEL_W] == '0) &&
		(rdata_ff[SEL_W-1:0] == $past(choice_ff)))
		else $error("select readback wrong or reserved bits set");

	a_pair_contested: assert property (@(posedge clk) disable iff (!nrst)
		(code_valid && !choice_ff[0] && !evt.contested[port_idx] && !wr_count) |=>
		$stable(count_ff))
		else $error("even code counted without a contested strobe");

	a_pair_all: assert property (@(posedge clk) disable iff (!nrst)
		(code_valid && choice_ff[0] && evt.access[port_idx] && !wr_count &&
		count_ff != CNT_MAX) |=> (count_ff != $past(count_ff)))
		else $error("odd code missed an access strobe");

	a_even_counts: assert property (@(posedge clk) disable iff (!nrst)
		(code_valid && !choice_ff[0] && evt.contested[port_idx] && !wr_count &&
		count_ff != CNT_MAX) |=> (count_ff != $past(count_ff)))
		else $error("even code missed a contested strobe");

	a_odd_access_only: assert property (@(posedge clk) disable iff (!nrst)
		(code_valid && choice_ff[0] && !evt.access[port_idx] && !wr_count) |=>
		$stable(count_ff))
		else $error("odd code counted without an access strobe");

	// spot checks of the port order, one per region of the code table
	a_apb_contested: assert property (@(posedge clk) disable iff (!nrst)
		(choice_ff == 5'h00) |-> (evt_hit == evt.contested[bfec_pkg::PORT_APB]))
		else $error("code 0x00 does not follow contested apb accesses");

	a_fastperi_all: assert property (@(posedge clk) disable iff (!nrst)
		(choice_ff == 5'h03) |-> (evt_hit == evt.access[bfec_pkg::PORT_FASTPERI]))
		else $error("code 0x03 does not follow fast peripheral accesses");

	a_bank5_contested: assert property (@(posedge clk) disable iff (!nrst)
		(choice_ff == 5'h04) |-> (evt_hit == evt.contested[bfec_pkg::PORT_BANK5]))
		else $error("code 0x04 does not follow contested bank five accesses");

	a_bank3_contested: assert property (@(posedge clk) disable iff (!nrst)
		(choice_ff == 5'h08) |-> (evt_hit == evt.contested[bfec_pkg::PORT_BANK3]))
		else $error("code 0x08 does not follow contested bank three accesses");

	a_bank2_all: assert property (@(posedge clk) disable iff (!nrst)
		(choice_ff == 5'h0B) |-> (evt_hit == evt.access[bfec_pkg::PORT_BANK2]))
		else $error("code 0x0b does not follow bank two accesses");

	a_xip_all: assert property (@(posedge clk) disable iff (!nrst)
		(choice_ff == 5'h11) |-> (evt_hit == evt.access[bfec_pkg::PORT_XIP]))
		else $error("code 0x11 does not follow xip accesses");

	a_rom_all: assert property (@(posedge clk) disable iff (!nrst)
		(choice_ff == 5'h13) |-> (evt_hit == evt.access[bfec_pkg::PORT_ROM]))
		else $error("code 0x13 does not follow rom accesses");

	// codes above the last pair never count; codes in the gaps between spot checks follow the pairing pattern

	a_high_code_idle: assert property (@(posedge clk) disable iff (!nrst)
		(choice_ff > SEL_HI && !wr_count) |=> $stable(count_ff))
		else $error("code above the last pair counted an event");

	a_bank0_all: assert property (@(posedge clk) disable iff (!nrst)
		(choice_ff == 5'h0F) |-> (evt_hit == evt.access[bfec_pkg::PORT_BANK0]))
		else $error("code 0x0f does not follow bank zero accesses");

	a_xip_contested: assert property (@(posedge clk) disable iff (!nrst)
		(choice_ff == 5'h10) |-> (evt_hit == evt.contested[bfec_pkg::PORT_XIP]))
		else $error("code 0x10 does not follow contested xip accesses");

endmodule

/* src/bfec_pkg.sv */
/*
 * Constants, register map and carrier types for the bus fabric event counter.
 * Assumes a single system clock and a simple word-wide peripheral register port.
 */
// Overview of operation
// - a 24-bit counter counts the selected arbiter event and saturates at maximum
// - any write to the count register clears it to zero, or to one when a selected event arrives in the same cycle; it is zero after reset
// - a 5-bit read-write select field in bits 4:0 resets to 0x1f
// - codes pair per port: even counts contested, odd counts all accesses
package bfec_pkg;

	localparam int CNT_W    = 24;
	localparam int SEL_W    = 5;
	localparam int PORT_N   = 10;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_COUNT  = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_CHOICE = 8'h24;

	// reset values
	localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
	localparam logic [SEL_W-1:0] SEL_RST = 5'h1F;

	// highest select code that names a port event
	localparam logic [SEL_W-1:0] CODE_LAST = 5'h13;

	// downstream port indices, in select-code pair order
	localparam int PORT_APB      = 0;
	localparam int PORT_FASTPERI = 1;
	localparam int PORT_BANK5    = 2;
	localparam int PORT_BANK4    = 3;
	localparam int PORT_BANK3    = 4;
	localparam int PORT_BANK2    = 5;
	localparam int PORT_BANK1    = 6;
	localparam int PORT_BANK0    = 7;
	localparam int PORT_XIP      = 8;
	localparam int PORT_ROM      = 9;

	// per-port strobes from the crossbar arbiters, bit index = port index
	typedef struct packed {
		logic [PORT_N-1:0] access;
		logic [PORT_N-1:0] contested;
	} bfec_evt_s;

	// register port request
	typedef struct packed {
		logic              sel;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bfec_req_s;

endpackage

/* src/bfec_sat_counter.sv */
/*
 * Saturating up-counter with synchronous clear.
 * Assumes inc and clear are single-cycle strobes in the clk domain.
 */
`timescale 1ns/1ps
module bfec_sat_counter #(
	parameter int W = bfec_pkg::CNT_W
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         clear,
	input  wire logic         inc,
	output logic [W-1:0]      count_ff
);

	localparam logic [W-1:0] ONE  = {{(W-1){1'b0}}, 1'b1};
	localparam logic [W-1:0] ZERO = '0;
	localparam logic [W-1:0] MAX  = '1;

	wire logic         at_max;
	wire logic [W-1:0] nxt_count;

	assign at_max = (count_ff == MAX);
	// an event in the clearing cycle is kept, so the count restarts at one
	assign nxt_count = clear ? (inc ? ONE : ZERO) :
	                   (inc && !at_max) ? count_ff + ONE : count_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_ff <= ZERO;
		end else begin
			count_ff <= nxt_count;
		end
	end

endmodule

/* tb/bfec_arbiter_model.sv */
/*
 * Behavioural crossbar arbiters: random per-port event strobes.
 * Assumes run and dense change just after a rising edge of clk.
 */
`timescale 1ns/1ps
module bfec_arbiter_model #(
	parameter int SEED = 32'h1B2C3D4E
) (
	input  wire logic           clk,
	input  wire logic           nrst,
	input  wire logic           run,
	input  wire logic           dense,
	output bfec_pkg::bfec_evt_s evt
);
	int         seed = SEED;
	logic [9:0] acc;
	// a contested access is always an access too
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			evt <= '0;
		end else begin
			acc = 10'($random(seed));
			evt.access <= dense ? '1 : (run ? acc : '0);
			evt.contested <= dense ? '1 : (run ? acc & 10'($random(seed)) : '0);
		end
	end
endmodule

/* tb/bus_fabric_event_counter_test.sv */
/*
 * Self-checking bench for the event counter and its register port.
 * Assumes the arbiter model drives evt; counter narrowed to 4 bits for saturation.
 */
`timescale 1ns/1ps
module bus_fabric_event_counter_test;
	localparam int          CW   = 4;
	localparam logic [31:0] CMAX = 32'h0000000F;
	logic                clk = 1'b0;
	logic                nrst;
	logic                run = 1'b0;
	logic                dense = 1'b0;
	bfec_pkg::bfec_evt_s evt;
	bfec_pkg::bfec_req_s req = '0;
	logic [31:0]         rdata;
	logic                rvalid;
	logic [31:0]         exp_cnt = 32'h0;
	logic [4:0]          exp_sel = 5'h1F;
	logic [31:0]         got;
	logic [31:0]         d;
	int                  seed = 32'h9061CE8A;
	int                  n_errors = 0;
	int                  n_checks = 0;
	int                  c;

	always #50 clk = ~clk;

	bfec_arbiter_model bfec_arbiter_model_i (.clk(clk), .nrst(nrst), .run(run), .dense(dense),
		.evt(evt));
	bfec_event_counter #(.CNT_W(CW)) bfec_event_counter_i (.clk(clk), .nrst(nrst), .evt(evt),
		.req(req), .rdata_ff(rdata), .rvalid_ff(rvalid));

	function automatic logic hit(input logic [4:0] code, input bfec_pkg::bfec_evt_s e);
		if (code > 5'h13) return 1'b0;
		return code[0] ? e.access[code[4:1]] : e.contested[code[4:1]];
	endfunction

	// reference model; an event in the write cycle uses the old select
	always @(posedge clk) begin
		if (!nrst) begin
			exp_cnt <= 32'h0;
			exp_sel <= 5'h1F;
		end else begin
			if (req.sel && req.wr && req.addr == 8'h20) exp_cnt <= {31'h0, hit(exp_sel, evt)};
			else if (hit(exp_sel, evt) && exp_cnt < CMAX) exp_cnt <= exp_cnt + 32'h1;
			if (req.sel && req.wr && req.addr == 8'h24) exp_sel <= req.wdata[4:0];
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		n_checks++;
		if (exp !== seen) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic put(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk) req <= {1'b1, 1'b1, a, v};
		@(posedge clk) req.sel <= 1'b0;
	endtask

	task automatic get(input logic [7:0] a, output logic [31:0] v);
		int i;
		@(posedge clk) req <= {1'b1, 1'b0, a, 32'h0};
		@(posedge clk) req.sel <= 1'b0;
		for (i = 0; i < 4; i++) begin
			@(negedge clk);
			if (rvalid === 1'b1) break;
		end
		chk("read latency", 32'h0, i);
		if (i == 4) summarize();
		v = rdata;
	endtask

	initial begin
		nrst = 1'b0;
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		get(8'h20, got);
		chk("count reset", 32'h0, got);
		get(8'h24, got);
		chk("select reset", 32'h1F, got);
		get(8'h28, got);
		chk("unmapped read", 32'h0, got);
		$display("reset test done");
		// every code, upper data bits random so reserved bits must read zero
		for (c = 0; c < 32; c++) begin
			d = $random(seed);
			d[4:0] = c[4:0];
			put(8'h24, d);
			get(8'h24, got);
			chk("select", {27'h0, c[4:0]}, got);
			@(posedge clk) run <= 1'b1;
			repeat (8) @(posedge clk);
			put(8'h20, $random(seed));
			repeat (6) @(posedge clk);
			run <= 1'b0;
			repeat (2) @(posedge clk);
			get(8'h20, got);
			chk("count", exp_cnt, got);
		end
		$display("code sweep done");
		put(8'h24, 32'h00000013);
		@(posedge clk) dense <= 1'b1;
		repeat (20) @(posedge clk);
		dense <= 1'b0;
		repeat (2) @(posedge clk);
		get(8'h20, got);
		chk("saturated count", CMAX, got);
		put(8'h20, 32'hFFFFFFFF);
		get(8'h20, got);
		chk("cleared count", 32'h0, got);
		$display("saturation test done");
		// reset in mid-run with events flowing and a non-default select
		put(8'h24, 32'h00000005);
		@(posedge clk) dense <= 1'b1;
		repeat (4) @(posedge clk);
		nrst <= 1'b0;
		dense <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		get(8'h20, got);
		chk("count after reset", 32'h0, got);
		get(8'h24, got);
		chk("select after reset", 32'h1F, got);
		$display("mid-run reset test done");
		summarize();
	end
endmodule
